//--- bench/pix_periph_model.sv
// Peripheral and pin event model: turns one-cycle commands into held request pulses.
// Assumes commands arrive on clk_i; pins are held long enough for the synchronisers.
`timescale 1ns/1ps
`default_nettype none
module pix_periph_model #(
  parameter int HOLD = 4
) (
  input  wire logic        clk_i,
  input  wire logic [31:0] fire_i,
  input  wire logic [3:0]  pin_fire_i,
  output logic [31:0]      src_req_o,
  output logic [3:0]       pin_o
);
  int          cnt [36];
  logic [35:0] all_fire;
  assign all_fire = {pin_fire_i, fire_i};
  // Rising edge per event, then back to idle low
  always @(posedge clk_i) begin
    for (int i = 0; i < 36; i++) begin
      if (all_fire[i]) cnt[i] <= HOLD;
      else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
    end
  end
  always_comb begin
    for (int i = 0; i < 32; i++) src_req_o[i] = cnt[i] > 0;
    for (int i = 0; i < 4; i++) pin_o[i] = cnt[32+i] > 0;
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench of the interrupt expansion block, registers over APB.
// Assumes pix_pkg, pix_top and pix_periph_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pix_pkg::*;
();
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, rst_pin_n, wdog, gdis, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, src_req, fire;
  logic [3:0]  pins, pin_fire;
  logic [5:0]  lvls;
  logic [15:0] vreg;
  pix_instr_t  instr;
  pix_branch_t branch;
  pix_branch_t brq[$];
  int          err_count, checked;
  int          vtab[int] = '{0:16'h0020, 1:16'h0004, 2:16'h0001, 3:16'h0011, 12:16'h0027, 13:16'h0028,
                             16:16'h0019, 19:16'h0026, 24:16'h0098, 26:16'h009a, 28:16'h009c, 30:16'h009e};
  int          ltab[int] = '{0:1, 1:1, 2:1, 3:1, 12:2, 13:2, 16:1, 19:2, 24:3, 26:4, 28:5, 30:6};
  int          srcs[11] = '{0, 1, 2, 3, 12, 16, 19, 24, 26, 28, 30};
  pix_instr_kind_t kinds[5] = '{PIX_INSTR_SOFT, PIX_INSTR_SOFT, PIX_INSTR_NMI, PIX_INSTR_TRAP, PIX_INSTR_TRAP};
  logic [4:0]  emus = 5'b10010;
  logic [4:0]  egd = 5'b00111;
  int          evec[5] = '{0, 16'h0026, 16'h0024, 16'h0022, 16'h0026};

  pix_top u_dut (
    .clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .rst_pin_n_i(rst_pin_n), .wdog_timeout_i(wdog), .ext_irq_pin_a_i(pins[1]), .ext_irq_pin_b_i(pins[2]),
    .power_protect_irq_a_i(pins[0]), .power_protect_irq_b_i(pins[3]), .src_req_i(src_req),
    .instr_i(instr), .branch_o(branch), .core_irq_levels_o(lvls), .expansion_vector_register_o(vreg),
    .global_irq_disable_o(gdis), .irq_o(irq)
  );

  pix_periph_model u_periph (
    .clk_i(clk), .fire_i(fire), .pin_fire_i(pin_fire), .src_req_o(src_req), .pin_o(pins)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Branch monitor
  always @(posedge clk) begin
    if (branch.valid === 1'b1) brq.push_back(branch);
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask

  // Pins 0,2,3,16 come from the pin inputs, the rest from peripheral lines
  task automatic fire_src(input int idx);
    case (idx)
      0: pin_fire <= 4'h1;
      2: pin_fire <= 4'h2;
      3: pin_fire <= 4'h4;
      16: pin_fire <= 4'h8;
      default: fire <= 32'h1 << idx;
    endcase
    @(posedge clk);
    pin_fire <= 4'h0;
    fire <= 32'h0;
    @(posedge clk);
  endtask

  task automatic wait_br(input logic [15:0] v, input logic rs);
    pix_branch_t b;
    int          n;
    n = 0;
    while (brq.size() == 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (brq.size() == 0) begin
      chk("branch", {15'h0, rs, v}, 32'hffff_ffff);
    end else begin
      b = brq.pop_front();
      chk("branch", {15'h0, rs, v}, {15'h0, b.is_reset, b.vector});
    end
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] op;
    int          i;
    {arst_n, psel, penable, pwrite, wdog, fire, pin_fire, paddr, pwdata} = '0;
    rst_pin_n = 1'b1;
    instr = '0;
    cyc(2);
    arst_n <= 1'b1;
    @(posedge clk);
    void'($urandom(32'h386d));
    rd("pin_en", 8'h00, 32'h0);
    rd("src_en", 8'h04, 32'h0);
    rd("pending", 8'h08, 32'h0);
    rd("vector", 8'h0c, 32'h00ff);
    rd("flag", 8'h10, 32'h0);
    rd("mask", 8'h14, 32'h0);
    rd("gdis", 8'h18, 32'h1);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    // Instruction vectoring
    for (int k = 0; k < 5; k++) begin
      op = 16'($urandom());
      wr(8'h18, 32'h0);
      instr <= '{1'b1, kinds[k], emus[k], op};
      @(posedge clk);
      instr <= '0;
      wait_br(k == 0 ? op : 16'(evec[k]), 1'b0);
      chk("gdis", {31'h0, egd[k]}, {31'h0, gdis});
    end
    // Each of the eleven sources in srcs: masked first, then taken on unmask
    wr(8'h00, 32'hf);
    for (int k = 0; k < 11; k++) begin
      i = srcs[k];
      wr(8'h04, 32'h1 << i);
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h0);
      fire_src(i);
      cyc(8);
      chk("levels", 32'h1 << (ltab[i] - 1), {26'h0, lvls});
      rd("pending", 8'h08, 32'h1 << i);
      chk("masked", 32'h0, brq.size());
      wr(8'h14, 32'h1 << (ltab[i] - 1));
      wait_br(16'(2 * ltab[i]), 1'b0);
      chk("vector", vtab[i], {16'h0, vreg});
      cyc(2);
      rd("pending", 8'h08, 32'h0);
      chk("levels", 32'h0, {26'h0, lvls});
    end
    // Disabled pin and disabled peripheral event
    wr(8'h04, 32'hffff_ffff);
    wr(8'h00, 32'h0);
    fire_src(2);
    cyc(8);
    wr(8'h04, 32'h0);
    fire_src(12);
    cyc(8);
    rd("pending", 8'h08, 32'h0);
    chk("levels", 32'h0, {26'h0, lvls});
    // Two sources on one level
    wr(8'h04, 32'h3000);
    wr(8'h14, 32'h2);
    fire_src(13);
    fire_src(12);
    cyc(8);
    rd("pending", 8'h08, 32'h3000);
    wr(8'h18, 32'h0);
    wait_br(16'h0004, 1'b0);
    chk("vector", 32'h0027, {16'h0, vreg});
    cyc(2);
    chk("levels", 32'h2, {26'h0, lvls});
    rd("pending", 8'h08, 32'h2000);
    // Watchdog reset
    wr(8'h14, 32'h3f);
    wr(8'h00, 32'hf);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    wait_br(16'h0000, 1'b1);
    rd("mask", 8'h14, 32'h0);
    rd("pin_en", 8'h00, 32'h0);
    rd("pending", 8'h08, 32'h0);
    rd("gdis", 8'h18, 32'h1);
    // Flag, mask and interrupt line
    wr(8'h04, 32'h1 << 24);
    fire_src(24);
    cyc(8);
    rd("flag", 8'h10, 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h14, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    // Flag re-sets while its level stands, so drop the source first
    wr(8'h04, 32'h0);
    rd("flag", 8'h10, 32'h4);
    wr(8'h10, 32'h4);
    rd("flag", 8'h10, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    chk("no_take", 32'h0, brq.size());
    // Reset pin
    rst_pin_n <= 1'b0;
    cyc(3);
    rst_pin_n <= 1'b1;
    wait_br(16'h0000, 1'b1);
    cyc(4);
    brq.delete();
    rd("mask", 8'h14, 32'h0);
    rd("pending", 8'h08, 32'h0);
    chk("gdis", 32'h1, {31'h0, gdis});
    conclude();
  end

  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire

//--- hdl/pix_params.svh
// Constants of the interrupt expansion block: offsets, bit positions, vectors, reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PIX_PARAMS_SVH
`define PIX_PARAMS_SVH
`define PIX_OFF_CTRL       8'h00
`define PIX_OFF_SRC_EN     8'h04
`define PIX_OFF_REQ        8'h08
`define PIX_OFF_VEC        8'h0c
`define PIX_OFF_FLAG       8'h10
`define PIX_OFF_MASK       8'h14
`define PIX_OFF_CORE       8'h18
`define PIX_NUM_SRC        32
`define PIX_NUM_LVL        6
`define PIX_BIT_PP_A       0
`define PIX_BIT_PIN_A      2
`define PIX_BIT_PIN_B      3
`define PIX_BIT_PP_B       16
`define PIX_VEC_RESET      16'h0000
`define PIX_VEC_TRAP       16'h0022
`define PIX_VEC_NMI        16'h0024
`define PIX_VEC_EMU        16'h0026
`define PIX_VEC_PHANTOM    16'h00ff
`define PIX_VEC_EXTRA_BASE 16'h0080
`define PIX_PIN_EN_RST     4'h0
`define PIX_SRC_EN_RST     32'h0000_0000
`define PIX_MASK_RST       6'h00
`define PIX_GDIS_RST       1'b1
`define PIX_RST_PIN_IDLE   1'b1
`endif

//--- hdl/pix_pkg.sv
// Types and source tables of the interrupt expansion block.
// Assumes pix_params.svh is on the include path.
`include "pix_params.svh"
package pix_pkg;
  typedef enum logic [1:0] {PIX_INSTR_SOFT, PIX_INSTR_NMI, PIX_INSTR_TRAP} pix_instr_kind_t;

  typedef struct packed {
    logic            valid;
    pix_instr_kind_t kind;
    logic            emu;
    logic [15:0]     operand;
  } pix_instr_t;

  typedef struct packed {
    logic        valid;
    logic        is_reset;
    logic [15:0] vector;
  } pix_branch_t;

  typedef struct packed {
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  pin_prev;
    logic        rst_s1;
    logic        rst_s2;
    logic [31:0] src_prev;
    logic [3:0]  pin_en;
    logic [31:0] src_en;
    logic [31:0] pend;
    logic [5:0]  lvl;
    logic [15:0] vec;
    logic [5:0]  flag;
    logic [5:0]  mask;
    logic        gdis;
    pix_branch_t br;
    logic [31:0] prdata;
    logic        pslverr;
  } pix_state_t;

  function automatic logic [2:0] pix_src_level(input logic [4:0] idx);
    if (idx <= 5'd11) return 3'd1;
    else if (idx <= 5'd15) return 3'd2;
    else if (idx == 5'd16) return 3'd1;
    else if (idx <= 5'd22) return 3'd2;
    else if (idx <= 5'd24) return 3'd3;
    else if (idx <= 5'd26) return 3'd4;
    else if (idx <= 5'd28) return 3'd5;
    else return 3'd6;
  endfunction

  function automatic logic [15:0] pix_src_vector(input logic [4:0] idx);
    case (idx)
      5'd0:    return 16'h0020;
      5'd1:    return 16'h0004;
      5'd2:    return 16'h0001;
      5'd3:    return 16'h0011;
      5'd4:    return 16'h0005;
      5'd5:    return 16'h0006;
      5'd6:    return 16'h0007;
      5'd7:    return 16'h0040;
      5'd8:    return 16'h0041;
      5'd9:    return 16'h0021;
      5'd10:   return 16'h0022;
      5'd11:   return 16'h0023;
      5'd12:   return 16'h0027;
      5'd13:   return 16'h0028;
      5'd14:   return 16'h0029;
      5'd15:   return 16'h002a;
      5'd16:   return 16'h0019;
      5'd17:   return 16'h0024;
      5'd18:   return 16'h0025;
      5'd19:   return 16'h0026;
      5'd20:   return 16'h002f;
      5'd21:   return 16'h0030;
      5'd22:   return 16'h0031;
      default: return `PIX_VEC_EXTRA_BASE | {11'h000, idx};
    endcase
  endfunction

  function automatic logic pix_addr_ok(input logic [7:0] a);
    return (a == `PIX_OFF_CTRL) || (a == `PIX_OFF_SRC_EN) || (a == `PIX_OFF_REQ) || (a == `PIX_OFF_VEC)
        || (a == `PIX_OFF_FLAG) || (a == `PIX_OFF_MASK) || (a == `PIX_OFF_CORE);
  endfunction
endpackage

//--- hdl/pix_top.sv
// Interrupt expansion unit with core flag, mask and global disable, reset and instruction vectoring.
// Assumes an APB master on clk_i, peripheral requests on clk_i, pins and reset pin asynchronous.
// Operation
// - Reset pre-empts everything at once, bypassing arbitration.
// - After reset all maskable interrupts stay disabled until software enables them.
// - Reset causes are only the reset pin and watchdog expiry.
// - Four pin requests need their own enable and the core mask bit.
// - Peripheral events need their event enable and the core mask bit.
// - Software interrupt branches to operand vector and sets global disable.
// - Non-maskable instruction branches to 24h and sets global disable; no pin.
// - Trap branches to 22h and leaves global disable unchanged.
// - Emulator trap reachable via software interrupt or trap instruction.
// - Peripheral requests grouped onto six core levels.
// - Each source has its own distinct vector value.
// - Reset is highest, non-maskable, vectors to 0000h.
// - Converter interrupt sits on level one, bit 0.1, vector 0004h.
// - Timer one period interrupt sits on level two, bit 0.12, vector 0027h.
//
// The register addresses and the APB register port are this design's own decisions.
`include "pix_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pix_top
  import pix_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        rst_pin_n_i,
  input  wire logic        wdog_timeout_i,
  input  wire logic        ext_irq_pin_a_i,
  input  wire logic        ext_irq_pin_b_i,
  input  wire logic        power_protect_irq_a_i,
  input  wire logic        power_protect_irq_b_i,
  input  wire logic [31:0] src_req_i,
  input  wire pix_instr_t  instr_i,
  output pix_branch_t      branch_o,
  output logic [5:0]       core_irq_levels_o,
  output logic [15:0]      expansion_vector_register_o,
  output logic             global_irq_disable_o,
  output logic             irq_o
);
  pix_state_t  s_q;
  pix_state_t  s_d;
  pix_state_t  s_rst;
  logic [31:0] req;
  logic [31:0] rise;
  logic [31:0] eff_en;
  logic [31:0] pend_clr;
  logic [5:0]  lvl_req;
  logic [5:0]  take_set;
  logic [5:0]  ack_hot;
  logic [5:0]  w1c;
  logic [2:0]  ack_lvl;
  logic [4:0]  sel_idx;
  logic        sel_hit;
  logic        rst_evt;
  logic        hw_take;
  logic        acc;
  logic        wr;
  logic        setup;

  function automatic logic [2:0] pix_first_level(input logic [5:0] v);
    logic [2:0] r;
    r = 3'd0;
    for (int k = `PIX_NUM_LVL - 1; k >= 0; k--) begin
      if (v[k]) r = 3'(k + 1);
    end
    return r;
  endfunction

  pix_vec_sel u_sel (
    .pend_i    (s_q.pend),
    .en_i      (eff_en),
    .lvl_i     (ack_lvl),
    .hit_o     (sel_hit),
    .idx_o     (sel_idx),
    .lvl_req_o (lvl_req)
  );

  always_comb begin
    s_rst          = '0;
    s_rst.rst_s1   = `PIX_RST_PIN_IDLE;
    s_rst.rst_s2   = `PIX_RST_PIN_IDLE;
    s_rst.pin_en   = `PIX_PIN_EN_RST;
    s_rst.src_en   = `PIX_SRC_EN_RST;
    s_rst.mask     = `PIX_MASK_RST;
    s_rst.gdis     = `PIX_GDIS_RST;
    s_rst.vec      = `PIX_VEC_PHANTOM;
  end

  always_comb begin
    s_d         = s_q;
    s_d.br      = '0;
    // Two-flop synchronisers, second stage feeds logic
    s_d.pin_s1  = {power_protect_irq_b_i, ext_irq_pin_b_i, ext_irq_pin_a_i, power_protect_irq_a_i};
    s_d.pin_s2  = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    s_d.rst_s1  = rst_pin_n_i;
    s_d.rst_s2  = s_q.rst_s1;
    s_d.src_prev = src_req_i;

    rst_evt = !s_q.rst_s2 || wdog_timeout_i;

    req                 = src_req_i;
    req[`PIX_BIT_PP_A]  = s_q.pin_s2[0];
    req[`PIX_BIT_PIN_A] = s_q.pin_s2[1];
    req[`PIX_BIT_PIN_B] = s_q.pin_s2[2];
    req[`PIX_BIT_PP_B]  = s_q.pin_s2[3];
    rise                = req & ~s_q.src_prev;
    rise[`PIX_BIT_PP_A] = s_q.pin_s2[0] & ~s_q.pin_prev[0];
    rise[`PIX_BIT_PIN_A] = s_q.pin_s2[1] & ~s_q.pin_prev[1];
    rise[`PIX_BIT_PIN_B] = s_q.pin_s2[2] & ~s_q.pin_prev[2];
    rise[`PIX_BIT_PP_B] = s_q.pin_s2[3] & ~s_q.pin_prev[3];

    eff_en                 = s_q.src_en;
    eff_en[`PIX_BIT_PP_A]  = s_q.src_en[`PIX_BIT_PP_A] & s_q.pin_en[0];
    eff_en[`PIX_BIT_PIN_A] = s_q.src_en[`PIX_BIT_PIN_A] & s_q.pin_en[1];
    eff_en[`PIX_BIT_PIN_B] = s_q.src_en[`PIX_BIT_PIN_B] & s_q.pin_en[2];
    eff_en[`PIX_BIT_PP_B]  = s_q.src_en[`PIX_BIT_PP_B] & s_q.pin_en[3];

    // Core takes a level only when no instruction and not globally disabled
    hw_take = !instr_i.valid && !s_q.gdis && ((s_q.flag & s_q.mask) != 6'h00);
    ack_lvl = hw_take ? pix_first_level(s_q.flag & s_q.mask) : 3'd0;
    ack_hot = 6'h00;
    pend_clr = 32'h0000_0000;
    if (hw_take) begin
      ack_hot[ack_lvl - 3'd1] = 1'b1;
      if (sel_hit) begin
        pend_clr[sel_idx] = 1'b1;
      end
    end

    // Set wins over clear on pending flags
    s_d.pend = (s_q.pend & ~pend_clr) | (rise & eff_en);
    s_d.lvl  = lvl_req;
    take_set = lvl_req & ~ack_hot;

    acc   = psel_i && penable_i;
    wr    = acc && pwrite_i;
    setup = psel_i && !penable_i;
    w1c   = 6'h00;
    if (wr) begin
      if (paddr_i == `PIX_OFF_CTRL) begin
        s_d.pin_en = pwdata_i[3:0];
      end else if (paddr_i == `PIX_OFF_SRC_EN) begin
        s_d.src_en = pwdata_i;
      end else if (paddr_i == `PIX_OFF_FLAG) begin
        w1c = pwdata_i[5:0];
      end else if (paddr_i == `PIX_OFF_MASK) begin
        s_d.mask = pwdata_i[5:0];
      end else if (paddr_i == `PIX_OFF_CORE) begin
        s_d.gdis = pwdata_i[0];
      end
    end
    s_d.flag = (s_q.flag & ~w1c & ~ack_hot) | take_set;

    if (setup) begin
      s_d.pslverr = !pix_addr_ok(paddr_i);
      if (paddr_i == `PIX_OFF_CTRL) begin
        s_d.prdata = {28'h000_0000, s_q.pin_en};
      end else if (paddr_i == `PIX_OFF_SRC_EN) begin
        s_d.prdata = s_q.src_en;
      end else if (paddr_i == `PIX_OFF_REQ) begin
        s_d.prdata = s_q.pend;
      end else if (paddr_i == `PIX_OFF_VEC) begin
        s_d.prdata = {16'h0000, s_q.vec};
      end else if (paddr_i == `PIX_OFF_FLAG) begin
        s_d.prdata = {26'h000_0000, s_q.flag};
      end else if (paddr_i == `PIX_OFF_MASK) begin
        s_d.prdata = {26'h000_0000, s_q.mask};
      end else if (paddr_i == `PIX_OFF_CORE) begin
        s_d.prdata = {31'h0000_0000, s_q.gdis};
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end

    if (instr_i.valid) begin
      s_d.br.valid = 1'b1;
      case (instr_i.kind)
        PIX_INSTR_SOFT: begin
          s_d.br.vector = instr_i.emu ? `PIX_VEC_EMU : instr_i.operand;
          s_d.gdis      = 1'b1;
        end
        PIX_INSTR_NMI: begin
          s_d.br.vector = `PIX_VEC_NMI;
          s_d.gdis      = 1'b1;
        end
        PIX_INSTR_TRAP: begin
          s_d.br.vector = instr_i.emu ? `PIX_VEC_EMU : `PIX_VEC_TRAP;
        end
        default: begin
          s_d.br.valid = 1'b0;
        end
      endcase
    end else if (hw_take) begin
      s_d.br.valid  = 1'b1;
      s_d.br.vector = {12'h000, ack_lvl, 1'b0};
      s_d.gdis      = 1'b1;
      s_d.vec       = sel_hit ? pix_src_vector(sel_idx) : `PIX_VEC_PHANTOM;
    end

    // Reset wins over every other request in the same cycle
    if (rst_evt) begin
      s_d             = s_rst;
      s_d.pin_s1      = {power_protect_irq_b_i, ext_irq_pin_b_i, ext_irq_pin_a_i, power_protect_irq_a_i};
      s_d.pin_s2      = s_q.pin_s1;
      s_d.pin_prev    = s_q.pin_s2;
      s_d.rst_s1      = rst_pin_n_i;
      s_d.rst_s2      = s_q.rst_s1;
      s_d.src_prev    = src_req_i;
      s_d.prdata      = s_q.prdata;
      s_d.pslverr     = s_q.pslverr;
      s_d.br.valid    = 1'b1;
      s_d.br.is_reset = 1'b1;
      s_d.br.vector   = `PIX_VEC_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '{rst_s1: `PIX_RST_PIN_IDLE, rst_s2: `PIX_RST_PIN_IDLE, pin_en: `PIX_PIN_EN_RST,
               src_en: `PIX_SRC_EN_RST, mask: `PIX_MASK_RST, gdis: `PIX_GDIS_RST,
               vec: `PIX_VEC_PHANTOM, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_o                    = 1'b1;
  assign prdata_o                    = s_q.prdata;
  assign pslverr_o                   = s_q.pslverr && psel_i && penable_i;
  assign branch_o                    = s_q.br;
  assign core_irq_levels_o           = s_q.lvl;
  assign expansion_vector_register_o = s_q.vec;
  assign global_irq_disable_o        = s_q.gdis;
  assign irq_o                       = (s_q.flag & s_q.mask) != 6'h00;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  logic [4:0] chk_idx_q;
  logic       chk_ack_q;
  logic       chk_l1_live;
  // Level one group: sources 0 to 11 and 16
  assign chk_l1_live = (s_q.pend & eff_en & 32'h0001_0fff) != 32'h0000_0000;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_idx_q <= 5'd0;
      chk_ack_q <= 1'b0;
    end else begin
      chk_idx_q <= sel_idx;
      chk_ack_q <= hw_take && sel_hit && !rst_evt;
    end
  end

  sequence s_reset_seen;
    rst_evt;
  endsequence

  sequence s_reset_branch;
    branch_o.valid && branch_o.is_reset && (branch_o.vector == 16'h0000);
  endsequence

  property p_reset_vector;
    s_reset_seen |=> s_reset_branch;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("reset did not vector to zero");

  property p_reset_masks;
    s_reset_seen |=> (s_q.mask == 6'h00) && global_irq_disable_o && (s_q.src_en == 32'h0);
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("masks not cleared by reset");

  property p_reset_cause;
    branch_o.is_reset |-> $past(rst_evt) && ($past(wdog_timeout_i) || !$past(s_q.rst_s2));
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset branch without cause");

  property p_pin_gate;
    !s_q.pin_en[1] && !s_q.pend[`PIX_BIT_PIN_A] && !rst_evt |=> !s_q.pend[`PIX_BIT_PIN_A];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("disabled pin set pending");

  property p_src_gate;
    !s_q.src_en[12] && !s_q.pend[12] && !rst_evt |=> !s_q.pend[12];
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("disabled source set pending");

  property p_mask_gate;
    (s_q.flag & s_q.mask) == 6'h00 && !instr_i.valid && !rst_evt |=> !branch_o.valid;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("branch taken with nothing unmasked");

  property p_soft;
    instr_i.valid && instr_i.kind == PIX_INSTR_SOFT && !instr_i.emu && !rst_evt
      |=> branch_o.valid && branch_o.vector == $past(instr_i.operand) && global_irq_disable_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft interrupt vector wrong");

  property p_nmi;
    instr_i.valid && instr_i.kind == PIX_INSTR_NMI && !rst_evt
      |=> branch_o.vector == 16'h0024 && global_irq_disable_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi vector wrong");

  property p_trap;
    instr_i.valid && instr_i.kind == PIX_INSTR_TRAP && !instr_i.emu && !rst_evt && !wr
      |=> branch_o.vector == 16'h0022 && global_irq_disable_o == $past(s_q.gdis);
  endproperty
  a_trap: assert property (p_trap) else $error("trap vector or disable wrong");

  property p_emu;
    instr_i.valid && instr_i.emu && instr_i.kind != PIX_INSTR_NMI && !rst_evt |=> branch_o.vector == 16'h0026;
  endproperty
  a_emu: assert property (p_emu) else $error("emulator trap vector wrong");

  property p_hw_take;
    hw_take && !rst_evt |=> branch_o.valid && branch_o.vector[15:4] == 12'h000
      && branch_o.vector[3:1] != 3'd0 && branch_o.vector[3:1] <= 3'd6 && global_irq_disable_o;
  endproperty
  a_hw_take: assert property (p_hw_take) else $error("level branch wrong");

  property p_ack_load;
    chk_ack_q |-> expansion_vector_register_o == pix_src_vector(chk_idx_q) && !s_q.pend[chk_idx_q];
  endproperty
  a_ack_load: assert property (p_ack_load) else $error("ack did not load and clear source");

  property p_converter;
    s_q.pend[1] && eff_en[1] && !rst_evt |=> core_irq_levels_o[0];
  endproperty
  a_converter: assert property (p_converter) else $error("converter not on level one");

  property p_timer;
    s_q.pend[12] && eff_en[12] && !rst_evt |=> core_irq_levels_o[1];
  endproperty
  a_timer: assert property (p_timer) else $error("timer period not on level two");

  property p_level_hold;
    chk_l1_live && !rst_evt |=> core_irq_levels_o[0];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level request dropped");
endmodule
`default_nettype wire

//--- hdl/pix_vec_sel.sv
// Level request builder and per-level source picker.
// Assumes pending and enable vectors from the same clock domain; purely combinational.
`include "pix_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pix_vec_sel
  import pix_pkg::*;
(
  input  wire logic [31:0] pend_i,
  input  wire logic [31:0] en_i,
  input  wire logic [2:0]  lvl_i,
  output logic             hit_o,
  output logic [4:0]       idx_o,
  output logic [5:0]       lvl_req_o
);
  logic [31:0] live;
  logic [2:0]  lv;

  always_comb begin
    live      = pend_i & en_i;
    hit_o     = 1'b0;
    idx_o     = 5'd0;
    lvl_req_o = 6'h00;
    lv        = 3'd0;
    // Lowest index wins inside a level
    for (int i = `PIX_NUM_SRC - 1; i >= 0; i--) begin
      lv = pix_src_level(5'(i));
      if (live[i]) begin
        lvl_req_o[lv - 3'd1] = 1'b1;
        if (lv == lvl_i) begin
          hit_o = 1'b1;
          idx_o = 5'(i);
        end
      end
    end
  end
endmodule
`default_nettype wire
